//--- hdl/tss_slave.sv
// sensor serial slave port: address match, pointer keep, timeout
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.svh"
module tss_slave #(
  parameter longint TOUT_CYC = `TSS_TOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  tss_bus_if.slave bus,
  // straps
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // register side
  input wire logic [15:0] rd_data,
  output logic [7:0] ptr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic busy
);
  import tss_pkg::*;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg;
  tss_slv_state_t st_reg, st_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic [15:0] tx_reg;
  logic byte_sel_reg, ptr_phase_reg, sda_oe_reg, wr_stb_reg;
  logic [7:0] ptr_reg, wr_data_reg;
  logic [2:0] strap_meta_reg, strap_reg;
  logic [63:0] to_cnt_reg;
  // synchronisers: stage 0 only feeds stage 1
  always_ff @(posedge clk) begin
    scl_sync_reg <= {scl_sync_reg[0], bus.scl};
    sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    scl_d_reg <= scl_sync_reg[1];
    sda_d_reg <= sda_sync_reg[1];
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [7:0] sh_in = {sh_reg[6:0], sda_s};
  wire [6:0] my_addr = {`TSS_ADDR_HI, strap_reg[2:0]};
  wire addr_hit = (sh_in[7:1] == my_addr);
  wire timeout = (to_cnt_reg >= TOUT_CYC[63:0]);
  wire byte_done = scl_rise & (bit_cnt_reg == 4'h7);
  // ack slots do not shift, so the direction bit survives the ninth pulse
  wire shift_en = scl_rise & (st_reg == TSS_ADDR | st_reg == TSS_WR | st_reg == TSS_RD);
  // address and write ack states hold one pulse: leave on the fall after their single rise
  wire ack_end = scl_fall & (bit_cnt_reg == 4'h1);
  // inside a read the shift lands on the same fall, so look one bit ahead
  wire tx_bit = (st_reg == TSS_RD) ? tx_reg[14] : tx_reg[15];
  // strap pins pass two flops before the address compare
  always_ff @(posedge clk) begin
    strap_meta_reg <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    strap_reg <= strap_meta_reg;
  end
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      TSS_IDLE: st_next = TSS_IDLE;
      TSS_ADDR: if (byte_done) begin
        st_next = addr_hit ? TSS_ADDR_ACK : TSS_WAIT;
      end
      TSS_ADDR_ACK: if (ack_end) begin
        st_next = sh_reg[0] ? TSS_RD : TSS_WR;
      end
      TSS_WR: if (byte_done) begin
        st_next = TSS_WR_ACK;
      end
      TSS_WR_ACK: if (ack_end) begin
        st_next = TSS_WR;
      end
      TSS_RD: if (byte_done) begin
        st_next = TSS_RD_ACK;
      end
      TSS_RD_ACK: if (scl_rise) begin
        st_next = sda_s ? TSS_WAIT : TSS_RD;
      end
      TSS_WAIT: st_next = TSS_WAIT;
      default: st_next = TSS_IDLE;
    endcase
    if (stop_det | timeout) begin
      st_next = TSS_IDLE;
    end
    if (start_det) begin
      st_next = TSS_ADDR;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= TSS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  // bit counter and shift register
  always_ff @(posedge clk) begin
    if (rst | start_det | (st_next != st_reg)) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
    if (rst) begin
      sh_reg <= 8'h00;
    end else if (shift_en) begin
      sh_reg <= sh_in;
    end
  end
  // timeout counter runs in every state except idle, wait after a foreign address included
  // the eeprom function is not modelled and keeps no timeout
  always_ff @(posedge clk) begin
    if (rst | st_reg == TSS_IDLE | scl_rise | scl_fall) begin
      to_cnt_reg <= 64'h0;
    end else begin
      to_cnt_reg <= to_cnt_reg + 64'h1;
    end
  end
  // pointer and write data; only the first written byte moves the pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= `TSS_PTR_RESET;
      wr_data_reg <= 8'h00;
      ptr_phase_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (st_reg == TSS_ADDR_ACK) begin
        ptr_phase_reg <= 1'b1;
      end else if (st_reg == TSS_WR & byte_done) begin
        ptr_phase_reg <= 1'b0;
        if (ptr_phase_reg) begin
          ptr_reg <= sh_in;
        end else begin
          wr_data_reg <= sh_in;
          wr_stb_reg <= 1'b1;
        end
      end
    end
  end
  // read data: high byte then low byte of the same register
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_reg <= 16'h0000;
      byte_sel_reg <= 1'b0;
    end else if (st_reg == TSS_ADDR_ACK) begin
      tx_reg <= rd_data;
      byte_sel_reg <= 1'b0;
    end else if (st_reg == TSS_RD & scl_fall) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
    end else if (st_reg == TSS_RD_ACK & scl_rise & ~byte_sel_reg) begin
      byte_sel_reg <= 1'b1;
    end
  end
  // sda driven only after scl falls
  always_ff @(posedge clk) begin
    if (rst | stop_det | start_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      case (st_next)
        TSS_ADDR_ACK: sda_oe_reg <= 1'b1;
        TSS_WR_ACK: sda_oe_reg <= 1'b1;
        TSS_RD: sda_oe_reg <= ~tx_bit;
        default: sda_oe_reg <= 1'b0;
      endcase
    end else if (st_reg != st_next & st_next == TSS_IDLE) begin
      sda_oe_reg <= 1'b0;
    end
  end
  // read bits change only on clock falls, msb of the register first
  assign bus.sda_s_oe = sda_oe_reg;
  assign ptr = ptr_reg;
  assign wr_data = wr_data_reg;
  assign wr_stb = wr_stb_reg;
  logic busy_reg;
  always_ff @(posedge clk) begin
    busy_reg <= ~rst & (st_next != TSS_IDLE);
  end
  assign busy = busy_reg;
endmodule
`default_nettype wire

//--- hdl/tss_consts.svh
// constants for the two-wire sensor slave port and its master end
// Notes on behaviour
// - address is 0011 plus three strap bits
// - straps give low bits, upper bits fixed
// - ack address only on exact match
// - eighth address bit: 1 read, 0 write
// - start is data falling while clock high
// - start mid-transfer restarts the state machine
// - stop is data rising while clock high
// - stop releases data line, goes idle
// - master opens with start+address, closes with stop
// - data changes only while clock low
// - receiver acks each byte on ninth pulse
// - master gives ninth clock pulse per byte
// - master naks last read byte; slave releases
// - no register auto-increment
// - pointer kept for later reads
// - clock stuck beyond timeout resets sensor port
// - eeprom function applies no clock timeout
// - idle is both lines high; slave never initiates
// - timeout between 25 and 50 ms, 40 typical
// - write sends pointer byte, upper bits zero
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_ADDR_HI 4'h3
`define TSS_PTR_RESET 8'h00
`define TSS_CLK_PERIOD_PS 5000
`define TSS_TOUT_MS 40
`define TSS_TOUT_CYC ((`TSS_TOUT_MS * 64'd1000000000) / `TSS_CLK_PERIOD_PS)
`define TSS_HALF_BIT_CYC 12'd1000
`endif

//--- hdl/tss_pkg.sv
// types shared by both ends of the two-wire port
package tss_pkg;
  typedef enum {
    TSS_IDLE, TSS_ADDR, TSS_ADDR_ACK, TSS_WR, TSS_WR_ACK, TSS_RD, TSS_RD_ACK, TSS_WAIT
  } tss_slv_state_t;
  typedef enum {
    TSM_IDLE, TSM_START, TSM_BIT_LO, TSM_BIT_HI, TSM_STOP_LO, TSM_STOP_HI, TSM_DONE
  } tss_mst_state_t;
endpackage

//--- hdl/tss_bus_if.sv
// two-wire bus carrier; resolves the open-drain wires from the enables
`timescale 1ns/1ps
`default_nettype none
interface tss_bus_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open drain: an enable pulls low, otherwise the pull-up wins
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport slave (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface
`default_nettype wire

//--- hdl/tss_master.sv
// host end: issues one byte-level transaction per request
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.svh"
module tss_master (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  tss_bus_if.master bus,
  // request: byte with start/stop framing
  input wire logic req,
  input wire logic req_start,
  input wire logic req_stop,
  input wire logic req_read,
  input wire logic req_nak,
  input wire logic [7:0] req_data,
  // answer
  output logic done,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  import tss_pkg::*;
  tss_mst_state_t st_reg;
  logic [11:0] div_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg;
  logic [7:0] rx_reg;
  logic [1:0] sda_sync_reg;
  logic scl_oe_reg, sda_oe_reg, done_reg, ack_reg, stop_reg;
  wire tick = (div_reg == `TSS_HALF_BIT_CYC);
  always_ff @(posedge clk) begin
    sda_sync_reg <= {sda_sync_reg[0], bus.sda};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= TSM_IDLE;
      div_reg <= 12'h000;
      bit_reg <= 4'h0;
      tx_reg <= 9'h1FF;
      rx_reg <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      div_reg <= (st_reg == TSM_IDLE | tick) ? 12'h000 : div_reg + 12'h001;
      case (st_reg)
        TSM_IDLE: if (req) begin
          // write bits, or released line with ack/nak in the ninth slot
          tx_reg <= req_read ? {8'hFF, req_nak} : {req_data, 1'b1};
          stop_reg <= req_stop;
          bit_reg <= 4'h0;
          st_reg <= req_start ? TSM_START : TSM_BIT_LO;
          if (req_start) begin
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
          end
        end
        TSM_START: if (tick) begin
          if (sda_oe_reg) begin
            scl_oe_reg <= 1'b1;
            st_reg <= TSM_BIT_LO;
          end else begin
            sda_oe_reg <= 1'b1;
          end
        end
        TSM_BIT_LO: if (tick) begin
          scl_oe_reg <= 1'b0;
          st_reg <= TSM_BIT_HI;
        end else if (div_reg == 12'h001) begin
          scl_oe_reg <= 1'b1;
          sda_oe_reg <= ~tx_reg[8];
        end
        TSM_BIT_HI: if (tick) begin
          scl_oe_reg <= 1'b1;
          tx_reg <= {tx_reg[7:0], 1'b1};
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg < 4'h8) begin
            rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
          end else begin
            ack_reg <= ~sda_sync_reg[1];
          end
          // nine pulses per byte
          st_reg <= (bit_reg == 4'h8) ? (stop_reg ? TSM_STOP_LO : TSM_DONE) : TSM_BIT_LO;
        end
        TSM_STOP_LO: if (tick) begin
          scl_oe_reg <= 1'b0;
          st_reg <= TSM_STOP_HI;
        end else if (div_reg == 12'h001) begin
          // pull data low while the clock is still low
          sda_oe_reg <= 1'b1;
        end
        TSM_STOP_HI: if (tick) begin
          sda_oe_reg <= 1'b0;
          st_reg <= TSM_DONE;
        end
        TSM_DONE: begin
          done_reg <= 1'b1;
          st_reg <= TSM_IDLE;
        end
        default: st_reg <= TSM_IDLE;
      endcase
    end
  end
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_oe = sda_oe_reg;
  assign done = done_reg;
  assign rsp_data = rx_reg;
  assign rsp_ack = ack_reg;
endmodule
`default_nettype wire

//--- test/tss_bus_checker.sv
// bus-level assertions between the master end and the slave end
`timescale 1ns/1ps
`default_nettype none
module tss_bus_checker #(
  parameter longint TOUT_CYC = 5000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wires and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, first_byte;
  logic [3:0] pos;
  longint stuck_cnt;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire scl_rise = scl && !scl_q;
  // pos counts clock pulses within a byte, 9 being the ack slot
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    stuck_cnt <= (rst || scl != scl_q) ? 64'd0 : stuck_cnt + 64'd1;
    if (rst || start_ev) begin
      pos <= 4'h0;
      first_byte <= 1'b1;
    end else if (scl_rise) begin
      pos <= (pos == 4'h9) ? 4'h1 : pos + 4'h1;
      first_byte <= first_byte && (pos != 4'h9);
    end
  end
  sequence start_seq;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence stop_seq;
    $rose(sda) && scl && $past(scl);
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_slave_set_low: assert property ($rose(sda_s_oe) |-> !scl) else $error("slave took data line with clock high");
  a_slave_free_low: assert property ($fell(sda_s_oe) |-> !scl) else $error("slave freed data line with clock high");
  a_slave_hold_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe)) else $error("slave data moved in high");
  a_slave_sync_lag: assert property ($rose(sda_s_oe) |-> !$past(scl) && !$past(scl, 2)) else $error("slave too early");
  a_start_by_master: assert property (start_seq |-> sda_m_oe && !sda_s_oe) else $error("start not from master");
  a_stop_release: assert property (stop_seq |-> !sda_s_oe [*8]) else $error("slave drives after stop");
  a_addr_ack_slot: assert property (sda_s_oe && first_byte |-> pos >= 4'h8) else $error("slave drove in address");
  a_tout_quiet: assert property (stuck_cnt > TOUT_CYC + 64 |-> !sda_s_oe) else $error("slave drives after timeout");
  c_start: cover property (start_seq);
endmodule
`default_nettype wire

//--- test/thermal_sensor_serial_slave_port_test.sv
// master end drives the slave end across the bus carrier
`timescale 1ns/1ps
`default_nettype none
module thermal_sensor_serial_slave_port_test;
  localparam longint TOUT = 5000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_start = 1'b0;
  logic req_stop = 1'b0;
  logic req_read = 1'b0;
  logic req_nak = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic [2:0] strap = 3'h5;
  logic [15:0] rd_data = 16'hC35A;
  logic done, rsp_ack, wr_stb, busy;
  logic [7:0] rsp_data, ptr, wr_data;
  int err_count = 0;
  int checked = 0;
  tss_bus_if bus_if();
  always #2.5 clk = ~clk;
  tss_slave #(.TOUT_CYC(TOUT)) u_tss_slave (.clk(clk), .rst(rst), .bus(bus_if), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .rd_data(rd_data), .ptr(ptr), .wr_data(wr_data),
    .wr_stb(wr_stb), .busy(busy));
  tss_master u_tss_master (.clk(clk), .rst(rst), .bus(bus_if), .req(req), .req_start(req_start),
    .req_stop(req_stop), .req_read(req_read), .req_nak(req_nak), .req_data(req_data), .done(done),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  tss_bus_checker #(.TOUT_CYC(TOUT)) u_tss_bus_checker (.clk(clk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .scl_m_oe(bus_if.scl_m_oe), .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one byte with optional start and stop; answer compared once done pulses
  task automatic xfer(input logic st, input logic sp, input logic rd, input logic nk, input logic [7:0] d,
    input logic [7:0] exp_d, input logic exp_ack);
    int n;
    req_start = st;
    req_stop = sp;
    req_read = rd;
    req_nak = nk;
    req_data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, done, 1'b1);
    end
    check(16'(rsp_ack), 16'(exp_ack));
    if (rd) check(16'(rsp_data), 16'(exp_d));
    repeat (8) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h3C, 8'h00, 1'b0);
    check(16'(busy), 16'h0000);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h3A, 8'h00, 1'b1);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h05, 8'h00, 1'b1);
    check(16'(ptr), 16'h0005);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h3A, 8'h00, 1'b1);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h3B, 8'h00, 1'b1);
    xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'hC3, 1'b1);
    xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h5A, 1'b0);
    check(16'(ptr), 16'h0005);
    check(16'(busy), 16'h0000);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h3A, 8'h00, 1'b1);
    check(16'(busy), 16'h0001);
    repeat (TOUT + 100) @(negedge clk);
    check(16'(busy), 16'h0000);
    wrap_up();
  end
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
